// >>> verilog/rmvr_defs.vh
// Constants for the rail mode and voltage control register bank.
`ifndef RMVR_DEFS_VH
`define RMVR_DEFS_VH

// Register indices; the byte address on the bus is four times the index.
`define RMVR_IDX_DEEP 6'h32
`define RMVR_IDX_PRIMARY 6'h33
`define RMVR_IDX_AON 6'h34
`define RMVR_IDX_DUAL 6'h35
`define RMVR_IDX_STATUS 6'h3F

// Reset values.
`define RMVR_RST_DEEP 8'h2A
`define RMVR_RST_PRIMARY 8'h0A
`define RMVR_RST_AON 8'h2A
`define RMVR_RST_DUAL 8'h0A

// Writable bits; the upper nibble of the load-switch registers is reserved.
`define RMVR_MASK_CONVERTER 8'hFF
`define RMVR_MASK_SWITCH 8'h0F

// Field positions inside a rail control register; the load switches have only the exit and mode fields.
`define RMVR_LPSET_MSB 7
`define RMVR_LPSET_LSB 6
`define RMVR_VSEL_MSB 5
`define RMVR_VSEL_LSB 4
`define RMVR_EXIT_MSB 3
`define RMVR_EXIT_LSB 2
`define RMVR_MODE_MSB 1
`define RMVR_MODE_LSB 0

// Field codes.
`define RMVR_CODE_OFF 2'h0
`define RMVR_MODE_FPWM 2'h3

// Rail trim in whole percent, two's complement.
`define RMVR_PCT_P3 4'h3
`define RMVR_PCT_P2 4'h2
`define RMVR_PCT_0 4'h0
`define RMVR_PCT_M2 4'hE
`define RMVR_PCT_M3 4'hD
`define RMVR_PCT_M4 4'hC

// Status register bit positions.
`define RMVR_ST_SLEEP 0
`define RMVR_ST_DEEP_LP 1
`define RMVR_ST_AON_LP 2
`define RMVR_ST_DEEP_EN 3
`define RMVR_ST_PRIMARY_EN 4
`define RMVR_ST_AON_EN 5
`define RMVR_ST_DUAL_EN 6

// Bus responses.
`define RMVR_RESP_OKAY 2'h0
`define RMVR_RESP_SLVERR 2'h2

`endif

// >>> verilog/rmvr_rail.v
// One rail control register with its sleep-entry and standby-exit behaviour.
`timescale 1ns/10ps
`default_nettype none
`include "rmvr_defs.vh"

module rmvr_rail #(
    parameter [7:0] RESET_VAL = `RMVR_RST_DEEP,
    parameter [7:0] WRITE_MASK = `RMVR_MASK_CONVERTER,
    parameter HAS_VSEL = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire wr_en,
    input wire [7:0] wr_data,
    input wire sleep_fall,
    input wire sleep_rise,
    output reg [7:0] reg_value,
    output reg rail_enable,
    output reg rail_forced_pwm,
    output reg lp_active,
    output reg [3:0] trim_pct
);

    // Normal output-voltage select code to percent trim.
    function [3:0] vsel_pct;
        input [1:0] code;
        begin
            case (code)
                2'h0: vsel_pct = `RMVR_PCT_P3;
                2'h1: vsel_pct = `RMVR_PCT_P2;
                2'h2: vsel_pct = `RMVR_PCT_0;
                default: vsel_pct = `RMVR_PCT_M2;
            endcase
        end
    endfunction

    // Low-power set-point code to percent trim; code 00 is never applied.
    function [3:0] lpset_pct;
        input [1:0] code;
        begin
            case (code)
                2'h1: lpset_pct = `RMVR_PCT_M4;
                2'h2: lpset_pct = `RMVR_PCT_M3;
                2'h3: lpset_pct = `RMVR_PCT_M2;
                default: lpset_pct = `RMVR_PCT_0;
            endcase
        end
    endfunction

    reg [1:0] lp_code;
    reg [7:0] next_value;
    reg next_lp;
    reg [1:0] next_lp_code;
    wire [1:0] exit_code = reg_value[`RMVR_EXIT_MSB:`RMVR_EXIT_LSB];
    wire [1:0] lp_field = reg_value[`RMVR_LPSET_MSB:`RMVR_LPSET_LSB];

    // The exit copy is applied after a bus write so hardware wins the mode bits.
    always @* begin
        next_value = reg_value;
        if (wr_en) begin
            next_value = wr_data & WRITE_MASK; // (R10) (R12)
        end
        if (sleep_rise && exit_code != `RMVR_CODE_OFF) begin
            next_value[`RMVR_MODE_MSB:`RMVR_MODE_LSB] = exit_code; // (R5) (R12)
        end
        next_lp = lp_active;
        next_lp_code = lp_code;
        if (sleep_fall) begin
            next_lp = (HAS_VSEL != 0) && (lp_field != `RMVR_CODE_OFF); // (R1) (R2) (R4)
            next_lp_code = lp_field;
        end else if (sleep_rise) begin
            next_lp = 1'b0;
        end
    end

    // State and decoded outputs all update on the same edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            reg_value <= RESET_VAL;
            lp_active <= 1'b0;
            lp_code <= `RMVR_CODE_OFF;
            rail_enable <= 1'b1;
            rail_forced_pwm <= 1'b0;
            trim_pct <= `RMVR_PCT_0;
        end else begin
            reg_value <= next_value;
            lp_active <= next_lp;
            lp_code <= next_lp_code;
            rail_enable <= next_value[`RMVR_MODE_MSB:`RMVR_MODE_LSB] != `RMVR_CODE_OFF; // (R6) (R7)
            rail_forced_pwm <= (HAS_VSEL != 0) &&
                (next_value[`RMVR_MODE_MSB:`RMVR_MODE_LSB] == `RMVR_MODE_FPWM); // (R6)
            if (HAS_VSEL == 0) begin
                trim_pct <= `RMVR_PCT_0;
            end else if (next_lp) begin
                trim_pct <= lpset_pct(next_lp_code); // (R1) (R4)
            end else begin
                trim_pct <= vsel_pct(next_value[`RMVR_VSEL_MSB:`RMVR_VSEL_LSB]); // (R2) (R3)
            end
        end
    end

endmodule // rmvr_rail

`default_nettype wire

// >>> verilog/rmvr_regs.v
// Register bank for four power rails, reached over AXI4-Lite.
//
// Notes on behaviour
// (R1) Deep-sleep rail moves to low-power set point 01/10/11 = -4/-3/-2% at sleep.
// (R2) Low-power code 00 keeps the normal voltage select during sleep.
// (R3) Voltage select 5:4: 00 +3%, 01 +2%, 10 nominal, 11 -2%; reset 10.
// (R4) Always-on 1.8 V rail has its own identical set-point and select fields.
// (R5) Sleep exit copies a nonzero exit code 3:2 into mode bits 1:0.
// (R6) Converter mode: 00 off, 01/10 auto PFM/PWM, 11 forced PWM.
// (R7) Load-switch mode: 00 disabled, anything else enabled.
// (R8) Primary switch register at index 0x33, reset 0x0A.
// (R9) Always-on 1.8 V register at index 0x34, reset 0x2A.
// (R10) Dual switch register at index 0x35, reset 0x0A, upper nibble read-only.
// (R11) Deep-sleep rail register at index 0x32, reset 0x2A.
// (R12) Reserved bits read zero and ignore writes; exit copies show on reads.
`timescale 1ns/10ps
`default_nettype none
`include "rmvr_defs.vh"

module rmvr_regs (
    input wire aclk,
    input wire aresetn,
    input wire sleep_state_n,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire deep_rail_enable,
    output wire deep_rail_forced_pwm,
    output wire [3:0] deep_rail_trim_pct,
    output wire primary_switch_enable,
    output wire aon_rail_enable,
    output wire aon_rail_forced_pwm,
    output wire [3:0] aon_rail_trim_pct,
    output wire dual_switch_enable
);

    // Register selector codes produced by the address decoder.
    localparam [2:0] SEL_DEEP = 3'h0;
    localparam [2:0] SEL_PRIMARY = 3'h1;
    localparam [2:0] SEL_AON = 3'h2;
    localparam [2:0] SEL_DUAL = 3'h3;
    localparam [2:0] SEL_STATUS = 3'h4;
    localparam [2:0] SEL_NONE = 3'h7;

    // Word-aligned decode shared by the write and read paths.
    function [2:0] decode_sel;
        input [7:0] addr;
        begin
            case (addr[7:2])
                `RMVR_IDX_DEEP: decode_sel = SEL_DEEP; // (R11)
                `RMVR_IDX_PRIMARY: decode_sel = SEL_PRIMARY; // (R8)
                `RMVR_IDX_AON: decode_sel = SEL_AON; // (R9)
                `RMVR_IDX_DUAL: decode_sel = SEL_DUAL; // (R10)
                `RMVR_IDX_STATUS: decode_sel = SEL_STATUS;
                default: decode_sel = SEL_NONE;
            endcase
        end
    endfunction

    // Sleep line history for edge detection; the input is already synchronous.
    reg sleep_q;
    wire sleep_fall = sleep_q & ~sleep_state_n;
    wire sleep_rise = ~sleep_q & sleep_state_n;

    // Reset assumes the platform is awake so no edge fires at release.
    always @(posedge aclk) begin
        if (!aresetn) begin
            sleep_q <= 1'b1;
        end else begin
            sleep_q <= sleep_state_n;
        end
    end

    // Write channel holding registers.
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr_q;
    reg [7:0] w_data_q;
    reg w_lane0_q;
    wire wr_go = aw_held & w_held & ~s_axi_bvalid;
    wire [2:0] wr_sel = decode_sel(aw_addr_q);
    wire wr_lane_ok = wr_go & w_lane0_q;

    // Per-rail write enables.
    wire wr_deep = wr_lane_ok && (wr_sel == SEL_DEEP);
    wire wr_primary = wr_lane_ok && (wr_sel == SEL_PRIMARY);
    wire wr_aon = wr_lane_ok && (wr_sel == SEL_AON);
    wire wr_dual = wr_lane_ok && (wr_sel == SEL_DUAL);

    // Address and data are accepted in any order; the write fires once both are in.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_lane0_q <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RMVR_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (wr_sel == SEL_NONE) begin
                    s_axi_bresp <= `RMVR_RESP_SLVERR;
                end else begin
                    s_axi_bresp <= `RMVR_RESP_OKAY;
                end
            end
            // Ready stays low until the response is taken, so one write is in flight.
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Rail register outputs.
    wire [7:0] deep_value;
    wire [7:0] primary_value;
    wire [7:0] aon_value;
    wire [7:0] dual_value;
    wire deep_lp;
    wire aon_lp;

    // Deep-sleep-well 3.3 V converter rail.
    rmvr_rail #(
        .RESET_VAL(`RMVR_RST_DEEP),
        .WRITE_MASK(`RMVR_MASK_CONVERTER),
        .HAS_VSEL(1)
    ) u_deep (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_deep),
        .wr_data(w_data_q),
        .sleep_fall(sleep_fall),
        .sleep_rise(sleep_rise),
        .reg_value(deep_value),
        .rail_enable(deep_rail_enable),
        .rail_forced_pwm(deep_rail_forced_pwm),
        .lp_active(deep_lp),
        .trim_pct(deep_rail_trim_pct)
    );

    // Primary-well 3.3 V load switch; its reserved nibble stays zero.
    rmvr_rail #(
        .RESET_VAL(`RMVR_RST_PRIMARY),
        .WRITE_MASK(`RMVR_MASK_SWITCH),
        .HAS_VSEL(0)
    ) u_primary (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_primary),
        .wr_data(w_data_q),
        .sleep_fall(sleep_fall),
        .sleep_rise(sleep_rise),
        .reg_value(primary_value),
        .rail_enable(primary_switch_enable),
        .rail_forced_pwm(),
        .lp_active(),
        .trim_pct()
    );

    // Always-on 1.8 V converter rail.
    rmvr_rail #(
        .RESET_VAL(`RMVR_RST_AON),
        .WRITE_MASK(`RMVR_MASK_CONVERTER),
        .HAS_VSEL(1)
    ) u_aon (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_aon),
        .wr_data(w_data_q),
        .sleep_fall(sleep_fall),
        .sleep_rise(sleep_rise),
        .reg_value(aon_value),
        .rail_enable(aon_rail_enable),
        .rail_forced_pwm(aon_rail_forced_pwm),
        .lp_active(aon_lp),
        .trim_pct(aon_rail_trim_pct)
    );

    // Dual 1.8 V / 2.5 V load switch.
    rmvr_rail #(
        .RESET_VAL(`RMVR_RST_DUAL),
        .WRITE_MASK(`RMVR_MASK_SWITCH),
        .HAS_VSEL(0)
    ) u_dual (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_en(wr_dual),
        .wr_data(w_data_q),
        .sleep_fall(sleep_fall),
        .sleep_rise(sleep_rise),
        .reg_value(dual_value),
        .rail_enable(dual_switch_enable),
        .rail_forced_pwm(),
        .lp_active(),
        .trim_pct()
    );

    // Status word built only from flops, so a read never sees a glitch.
    reg [7:0] status_value;

    always @* begin
        status_value = 8'h00;
        status_value[`RMVR_ST_SLEEP] = ~sleep_q;
        status_value[`RMVR_ST_DEEP_LP] = deep_lp;
        status_value[`RMVR_ST_AON_LP] = aon_lp;
        status_value[`RMVR_ST_DEEP_EN] = deep_rail_enable;
        status_value[`RMVR_ST_PRIMARY_EN] = primary_switch_enable;
        status_value[`RMVR_ST_AON_EN] = aon_rail_enable;
        status_value[`RMVR_ST_DUAL_EN] = dual_switch_enable;
    end

    // Read data selection; narrow registers sit in the low byte.
    wire [2:0] rd_sel = decode_sel(s_axi_araddr);
    reg [7:0] rd_byte;

    always @* begin
        case (rd_sel)
            SEL_DEEP: rd_byte = deep_value;
            SEL_PRIMARY: rd_byte = primary_value; // (R12)
            SEL_AON: rd_byte = aon_value;
            SEL_DUAL: rd_byte = dual_value; // (R12)
            SEL_STATUS: rd_byte = status_value;
            default: rd_byte = 8'h00;
        endcase
    end

    // Read channel: one read in flight, answered one edge after the address.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RMVR_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                if (rd_sel == SEL_NONE) begin
                    s_axi_rresp <= `RMVR_RESP_SLVERR;
                end else begin
                    s_axi_rresp <= `RMVR_RESP_OKAY;
                end
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // rmvr_regs

`default_nettype wire

// >>> tb/rmvr_platform.sv
// Platform model that drives the sleep line of the rail register bank.
`timescale 1ns/10ps
`default_nettype none

module rmvr_platform #(
    parameter int LAG = 1
) (
    input wire logic aclk,
    input wire logic sleep_req,
    output logic sleep_state_n
);
    logic [7:0] hist = 8'hFF;

    // The line settles LAG clocks after the request; a larger LAG models a slow platform.
    always @(posedge aclk) begin
        hist <= {hist[6:0], sleep_req};
    end
    assign sleep_state_n = hist[LAG-1];
endmodule // rmvr_platform
`default_nettype wire

// >>> tb/rmvr_regs_properties.sv
// Port-level properties of the rail register bank.
`timescale 1ns/10ps
`default_nettype none

module rmvr_regs_props (
    input wire aclk,
    input wire aresetn,
    input wire sleep_state_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire deep_rail_enable,
    input wire deep_rail_forced_pwm,
    input wire [3:0] deep_rail_trim_pct,
    input wire [3:0] aon_rail_trim_pct,
    input wire primary_switch_enable
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Bus answers and their holding behaviour.
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
    // The write fires one edge after both halves are in, so bvalid shows two edges later.
    property p_wr_ans;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
    // A pending response must keep the next write out, or a second write could slip in.
    property p_b_hold; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
    a_b_hold: assert property (p_b_hold) else $error("write taken during response");
    property p_r_hold; s_axi_rvalid |-> !s_axi_arready; endproperty
    a_r_hold: assert property (p_r_hold) else $error("read taken during answer");
    property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");

    // Rail outputs tied to their causes.
    property p_fpwm; deep_rail_forced_pwm |-> deep_rail_enable; endproperty
    a_fpwm: assert property (p_fpwm) else $error("forced PWM while off");
    property p_awake_trim;
        sleep_state_n && $past(sleep_state_n) |-> deep_rail_trim_pct inside {4'h3, 4'h2, 4'h0, 4'hE};
    endproperty
    a_awake_trim: assert property (p_awake_trim) else $error("awake trim bad");
    property p_aon_trim;
        sleep_state_n && $past(sleep_state_n) |-> aon_rail_trim_pct inside {4'h3, 4'h2, 4'h0, 4'hE};
    endproperty
    a_aon_trim: assert property (p_aon_trim) else $error("awake aon trim bad");
    // The exit copy lands on the edge that first sees the line high, one sample late here.
    property p_en_cause;
        $changed(primary_switch_enable) |->
            ($past(sleep_state_n) && !$past(sleep_state_n, 2)) || $rose(s_axi_bvalid);
    endproperty
    a_en_cause: assert property (p_en_cause) else $error("switch changed alone");

    c_sleep_lp: cover property ($fell(sleep_state_n) ##1 deep_rail_trim_pct[3]);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_exit_fpwm: cover property ($rose(sleep_state_n) ##1 $rose(deep_rail_forced_pwm));
endmodule // rmvr_regs_props

bind rmvr_regs rmvr_regs_props rmvr_regs_props_inst (.aclk, .aresetn, .sleep_state_n,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .deep_rail_enable, .deep_rail_forced_pwm, .deep_rail_trim_pct, .aon_rail_trim_pct,
    .primary_switch_enable);
`default_nettype wire

// >>> tb/rmvr_regs_test.sv
// Self-checking bench for the rail register bank.
`timescale 1ns/10ps
`default_nettype none
`include "rmvr_defs.vh"

module rmvr_regs_test;
    logic aclk = 1'b0, aresetn = 1'b0, sleep_req = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, cv, sw, st;
    logic [31:0] wdata = 32'h0, seed = 32'h555918B0;
    logic [1:0] nm, ns;
    wire sleep_n, awready, wready, bvalid, arready, rvalid;
    wire deep_en, deep_fp, prim_en, aon_en, aon_fp, dual_en;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] deep_trim, aon_trim;
    integer fail_count = 0, n_checks = 0, k;

    // Clock of 100 ns period.
    always #50 aclk = ~aclk;

    rmvr_platform #(.LAG(1)) rmvr_platform_inst (.aclk(aclk), .sleep_req(sleep_req),
        .sleep_state_n(sleep_n));
    rmvr_regs rmvr_regs_inst (.aclk(aclk), .aresetn(aresetn), .sleep_state_n(sleep_n),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .deep_rail_enable(deep_en), .deep_rail_forced_pwm(deep_fp),
        .deep_rail_trim_pct(deep_trim), .primary_switch_enable(prim_en),
        .aon_rail_enable(aon_en), .aon_rail_forced_pwm(aon_fp),
        .aon_rail_trim_pct(aon_trim), .dual_switch_enable(dual_en));

    function automatic [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin
            t = s ^ (s << 13);
            t = t ^ (t >> 17);
            xs = t ^ (t << 5);
        end
    endfunction

    // Trim picked by the voltage select, and by the low-power code while asleep.
    function automatic [3:0] vtrim(input [1:0] v);
        vtrim = (v == 2'h0) ? `RMVR_PCT_P3 : (v == 2'h1) ? `RMVR_PCT_P2 :
            (v == 2'h2) ? `RMVR_PCT_0 : `RMVR_PCT_M2;
    endfunction
    function automatic [3:0] lptrim(input [1:0] c, input [1:0] v);
        lptrim = (c == 2'h0) ? vtrim(v) : (c == 2'h1) ? `RMVR_PCT_M4 :
            (c == 2'h2) ? `RMVR_PCT_M3 : `RMVR_PCT_M2;
    endfunction

    task automatic stop_test;
        begin
            if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask

    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    // A hung bus counts as a mismatch and ends the run.
    task automatic hung;
        begin
            fail_count = fail_count + 1;
            stop_test;
        end
    endtask

    task automatic wr(input [7:0] a, input [7:0] d, input [1:0] er);
        integer i;
        logic done;
        begin
            done = 1'b0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (i = 0; i < 40 && !done; i = i + 1) begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) begin
                    chk({30'h0, bresp}, {30'h0, er});
                    bready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done) hung;
        end
    endtask

    task automatic rd(input [7:0] a, input [7:0] ed, input [1:0] er);
        integer i;
        logic done;
        begin
            done = 1'b0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (i = 0; i < 40 && !done; i = i + 1) begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) begin
                    chk(rdata, {24'h0, ed});
                    chk({30'h0, rresp}, {30'h0, er});
                    rready <= 1'b0;
                    done = 1'b1;
                end
            end
            if (!done) hung;
        end
    endtask

    // Main sequence: reset values, refusals, then random sleep rounds with corners first.
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'hC8, `RMVR_RST_DEEP, `RMVR_RESP_OKAY);
        rd(8'hCC, `RMVR_RST_PRIMARY, `RMVR_RESP_OKAY);
        rd(8'hD0, `RMVR_RST_AON, `RMVR_RESP_OKAY);
        rd(8'hD4, `RMVR_RST_DUAL, `RMVR_RESP_OKAY);
        rd(8'h40, 8'h00, `RMVR_RESP_SLVERR);
        wr(8'h44, 8'hFF, `RMVR_RESP_SLVERR);
        for (k = 0; k < 14; k = k + 1) begin
            seed = xs(seed);
            // Corner 1 starts a converter off with exit code 11, so forced PWM rises at exit.
            cv = (k == 0) ? 8'h00 : (k == 1) ? 8'hFC : seed[7:0];
            sw = (k == 0) ? 8'hF0 : (k == 1) ? 8'hFC : seed[15:8];
            wr(8'hC8, cv, `RMVR_RESP_OKAY);
            wr(8'hD0, cv ^ 8'h30, `RMVR_RESP_OKAY);
            wr(8'hCC, sw, `RMVR_RESP_OKAY);
            wr(8'hD4, sw, `RMVR_RESP_OKAY);
            chk({28'h0, deep_trim}, {28'h0, vtrim(cv[5:4])});
            chk({28'h0, aon_trim}, {28'h0, vtrim(~cv[5:4])});
            chk({30'h0, deep_fp, deep_en}, {30'h0, cv[1:0] == 2'h3, cv[1:0] != 2'h0});
            chk({30'h0, prim_en, dual_en}, {30'h0, {2{sw[1:0] != 2'h0}}});
            sleep_req <= 1'b0;
            repeat (4) @(posedge aclk);
            chk({28'h0, deep_trim}, {28'h0, lptrim(cv[7:6], cv[5:4])});
            chk({28'h0, aon_trim}, {28'h0, lptrim(cv[7:6], ~cv[5:4])});
            // Status while asleep: enables, both low-power flags and the sleep bit.
            st = {1'b0, {2{sw[1:0] != 2'h0, cv[1:0] != 2'h0}}, {2{cv[7:6] != 2'h0}}, 1'b1};
            rd(8'hFC, st, `RMVR_RESP_OKAY);
            sleep_req <= 1'b1;
            repeat (4) @(posedge aclk);
            nm = (cv[3:2] != 2'h0) ? cv[3:2] : cv[1:0];
            ns = (sw[3:2] != 2'h0) ? sw[3:2] : sw[1:0];
            chk({28'h0, aon_fp, aon_en, deep_fp, deep_en},
                {28'h0, {2{nm == 2'h3, nm != 2'h0}}});
            chk({30'h0, prim_en, dual_en}, {30'h0, {2{ns != 2'h0}}});
            rd(8'hC8, {cv[7:2], nm}, `RMVR_RESP_OKAY);
            rd(8'hD0, {cv[7:6], ~cv[5:4], cv[3:2], nm}, `RMVR_RESP_OKAY);
            rd(8'hCC, {4'h0, sw[3:2], ns}, `RMVR_RESP_OKAY);
            rd(8'hD4, {4'h0, sw[3:2], ns}, `RMVR_RESP_OKAY);
        end
        stop_test;
    end
endmodule // rmvr_regs_test
`default_nettype wire
